// file: verilog/cit_pkg.sv
/*
 * Constants and types for the instruction cycle timing controller.
 * Assumes a single clock domain; counts are in system clock cycles.
 */
`default_nettype none

package cit_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    typedef logic [3:0] cit_cnt_t;
    typedef logic [1:0] cit_bytes_t;

    // ************************************************************
    // Cycle counts
    // ************************************************************
    localparam cit_cnt_t CIT_CYC_0   = 4'h0;
    localparam cit_cnt_t CIT_CYC_1   = 4'h1;
    localparam cit_cnt_t CIT_CYC_2   = 4'h2;
    localparam cit_cnt_t CIT_CYC_3   = 4'h3;
    localparam cit_cnt_t CIT_CYC_4   = 4'h4;
    localparam cit_cnt_t CIT_CYC_5   = 4'h5;
    localparam cit_cnt_t CIT_CYC_8   = 4'h8;
    localparam cit_cnt_t CIT_CYC_MAX = CIT_CYC_8;
    localparam cit_cnt_t CIT_TAKEN_PENALTY = 4'h1;

    // ************************************************************
    // Program byte counts
    // ************************************************************
    localparam cit_bytes_t CIT_BY_0 = 2'h0;
    localparam cit_bytes_t CIT_BY_1 = 2'h1;
    localparam cit_bytes_t CIT_BY_2 = 2'h2;
    localparam cit_bytes_t CIT_BY_3 = 2'h3;
    localparam cit_bytes_t CIT_BY_STEP = 2'h1;

    // ************************************************************
    // Decode result and states
    // ************************************************************
    typedef struct packed {
        cit_bytes_t bytes;
        cit_cnt_t   cycles;
        logic       cond;
    } cit_dec_s;

    typedef enum logic [1:0] {
        CIT_IDLE = 2'b01,
        CIT_EXEC = 2'b10
    } cit_state_e;

endpackage

`default_nettype wire

// file: verilog/cit_byte_seq.sv
/*
 * Program byte fetch sequencer: one fetch strobe per program byte,
 * one byte per clock, starting in the first cycle of an instruction.
 * Assumes load comes from logic on the same clock.
 */
`default_nettype none

module cit_byte_seq
    import cit_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Instruction start
    input  wire logic                load,
    input  wire cit_pkg::cit_bytes_t load_bytes,
    // Fetch strobes
    output var  logic                fetch,
    output var  cit_pkg::cit_bytes_t fetch_idx
);

    import cit_pkg::*;

    typedef struct packed {
        cit_bytes_t left;
        cit_bytes_t idx;
        logic       fetch;
    } cit_seq_s;

    cit_seq_s s_q;
    cit_seq_s s_d;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.fetch = 1'b0;
        if (load) begin
            s_d.fetch = 1'b1;
            s_d.idx   = CIT_BY_1;
            s_d.left  = load_bytes - CIT_BY_STEP;
        end else if (s_q.left != CIT_BY_0) begin
            s_d.fetch = 1'b1;
            s_d.idx   = s_q.idx + CIT_BY_STEP;
            s_d.left  = s_q.left - CIT_BY_STEP;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{CIT_BY_0, CIT_BY_0, 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign fetch     = s_q.fetch;
    assign fetch_idx = s_q.idx;

endmodule

`default_nettype wire

// file: verilog/cit_timing_ctrl.sv
/*
 * Instruction cycle timing controller: decodes an opcode into its
 * program byte count and execution length, then holds the core busy
 * for exactly that many clocks, one program byte fetched per clock.
 * Assumes fetch presents opcode and branch outcome on the same clock.
 */
// Summary of operation
// - Durations count system clocks, no machine cycles
// - Most instructions: cycles equal program bytes
// - Untaken conditional branch ends one cycle sooner
// - Arithmetic with working register: 1 byte, 1 cycle
// - Arithmetic direct or immediate: 2 bytes, 2 cycles
// - Arithmetic indirect RAM: 1 byte, 2 cycles
// - Logical with working register: 1 byte, 1 cycle
// - Logical indirect RAM into accumulator: 2 cycles
// - Logical accumulator into direct: 2 bytes, 2 cycles
// - Logical immediate into direct: 3 bytes, 3 cycles
// - Single-byte accumulator operations take 1 cycle
// - Working register to direct: 2 bytes, 2 cycles
// - Direct to direct move: 3 bytes, 3 cycles
// - Accumulator to indirect RAM: 1 byte, 2 cycles
// - Immediate to indirect RAM: 2 bytes, 2 cycles
// - Load data pointer immediate: 3 bytes, 3 cycles
// - Code memory read: 1 byte, 3 cycles
// - External data moves: 1 byte, 3 cycles
// - Push direct: 2 bytes, 2 cycles
// - Pop direct: 2 bytes, 2 cycles
// - Exchange working register: 1 byte, 1 cycle
// - Low nibble exchange: 1 byte, 2 cycles
// - No instruction exceeds eight cycles
// - Standard opcode encodings; only timing differs
// - Carry jumps: 2 untaken, 3 taken
`default_nettype none

module cit_timing_ctrl
    import cit_pkg::*;
(
    // Clock and reset
    input  wire logic                REF_CLK,
    input  wire logic                RST_N,
    // Instruction from fetch
    input  wire logic                OPC_VALID,
    input  wire logic [7:0]          OPC,
    input  wire logic                COND_TAKEN,
    output var  logic                OPC_READY,
    // Execution status
    output var  logic                BUSY,
    output var  logic                DONE,
    output var  cit_pkg::cit_cnt_t   CYCLE_TOTAL,
    output var  cit_pkg::cit_cnt_t   CYCLE_NUM,
    output var  cit_pkg::cit_bytes_t BYTE_COUNT,
    output var  logic                BRANCH_TAKEN,
    // Program byte fetch
    output var  logic                PROG_FETCH,
    output var  cit_pkg::cit_bytes_t FETCH_INDEX
);

    import cit_pkg::*;

    typedef struct packed {
        cit_state_e state;
        cit_cnt_t   remain;
        cit_cnt_t   num;
        cit_cnt_t   total;
        cit_bytes_t bytes;
        logic       taken;
        logic       busy;
        logic       done;
        logic       ready;
    } cit_ctrl_s;

    localparam cit_ctrl_s CIT_RESET = '{
        state  : CIT_IDLE,
        remain : CIT_CYC_0,
        num    : CIT_CYC_0,
        total  : CIT_CYC_0,
        bytes  : CIT_BY_0,
        taken  : 1'b0,
        busy   : 1'b0,
        done   : 1'b0,
        ready  : 1'b1
    };

    cit_ctrl_s  s_q;
    cit_ctrl_s  s_d;
    cit_dec_s   dec;
    cit_cnt_t   total_raw;
    cit_cnt_t   total;
    logic       taken;
    logic       accept;

    // ************************************************************
    // Opcode decode
    // ************************************************************
    always_comb begin
        dec = '{CIT_BY_1, CIT_CYC_1, 1'b0};
        casez (OPC)
            // Arithmetic on working register
            8'b0010_1???, 8'b0011_1???, 8'b1001_1???:
                dec = '{CIT_BY_1, CIT_CYC_1, 1'b0};
            // Arithmetic on direct byte or immediate
            8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b0};
            // Arithmetic on indirect RAM
            8'b0010_011?, 8'b0011_011?, 8'b1001_011?:
                dec = '{CIT_BY_1, CIT_CYC_2, 1'b0};
            // Increment and decrement
            8'h04, 8'h14, 8'b0000_1???, 8'b0001_1???, 8'hA3, 8'hD4:
                dec = '{CIT_BY_1, CIT_CYC_1, 1'b0};
            8'h05, 8'h15:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b0};
            8'b0000_011?, 8'b0001_011?:
                dec = '{CIT_BY_1, CIT_CYC_2, 1'b0};
            // Multiply and divide
            8'hA4:
                dec = '{CIT_BY_1, CIT_CYC_4, 1'b0};
            8'h84:
                dec = '{CIT_BY_1, CIT_CYC_8, 1'b0};
            // Logical with working register
            8'b0100_1???, 8'b0101_1???, 8'b0110_1???:
                dec = '{CIT_BY_1, CIT_CYC_1, 1'b0};
            // Logical with indirect RAM
            8'b0100_011?, 8'b0101_011?, 8'b0110_011?:
                dec = '{CIT_BY_1, CIT_CYC_2, 1'b0};
            // Logical direct or immediate into accumulator
            8'h44, 8'h45, 8'h54, 8'h55, 8'h64, 8'h65:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b0};
            // Logical accumulator into direct byte
            8'h42, 8'h52, 8'h62:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b0};
            // Logical immediate into direct byte
            8'h43, 8'h53, 8'h63:
                dec = '{CIT_BY_3, CIT_CYC_3, 1'b0};
            // Single-byte accumulator operations
            8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4:
                dec = '{CIT_BY_1, CIT_CYC_1, 1'b0};
            // Moves between accumulator and working register
            8'b1110_1???, 8'b1111_1???:
                dec = '{CIT_BY_1, CIT_CYC_1, 1'b0};
            // Two-byte moves, then one-byte indirect forms taking 2 cycles
            8'hE5, 8'h74, 8'b1010_1???, 8'b0111_1???, 8'hF5,
            8'b1000_011?, 8'b1010_011?:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b0};
            8'b1110_011?, 8'b1100_011?:
                dec = '{CIT_BY_1, CIT_CYC_2, 1'b0};
            // Working register to direct byte
            8'b1000_1???:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b0};
            // Direct to direct, immediate to direct
            8'h85:
                dec = '{CIT_BY_3, CIT_CYC_3, 1'b0};
            8'h75:
                dec = '{CIT_BY_3, CIT_CYC_3, 1'b0};
            // Accumulator to indirect RAM
            8'b1111_011?:
                dec = '{CIT_BY_1, CIT_CYC_2, 1'b0};
            // Immediate to indirect RAM
            8'b0111_011?:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b0};
            // Load data_pointer_16
            8'h90:
                dec = '{CIT_BY_3, CIT_CYC_3, 1'b0};
            // code_memory_read via data pointer or program counter
            8'h93, 8'h83:
                dec = '{CIT_BY_1, CIT_CYC_3, 1'b0};
            // external_data_move, both widths, both directions
            8'hE0, 8'hF0, 8'b1110_001?, 8'b1111_001?:
                dec = '{CIT_BY_1, CIT_CYC_3, 1'b0};
            // Stack push and pop
            8'hC0:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b0};
            8'hD0:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b0};
            // Exchanges
            8'b1100_1???:
                dec = '{CIT_BY_1, CIT_CYC_1, 1'b0};
            8'hC5:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b0};
            8'b1101_011?:
                dec = '{CIT_BY_1, CIT_CYC_2, 1'b0};
            // Carry and bit operations
            8'hC3, 8'hD3, 8'hB3:
                dec = '{CIT_BY_1, CIT_CYC_1, 1'b0};
            8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b0};
            // Conditional jumps on carry, zero, register count
            8'h40, 8'h50:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b1};
            8'h60, 8'h70, 8'b1101_1???:
                dec = '{CIT_BY_2, CIT_CYC_2, 1'b1};
            // Conditional jumps on bit, compare, direct count
            8'h10, 8'h20, 8'h30, 8'hB4, 8'b1011_1???, 8'hD5:
                dec = '{CIT_BY_3, CIT_CYC_3, 1'b1};
            8'hB5, 8'b1011_011?:
                dec = '{CIT_BY_3, CIT_CYC_4, 1'b1};
            // Unconditional branches, calls, returns
            8'b???0_0001, 8'b???1_0001, 8'h80:
                dec = '{CIT_BY_2, CIT_CYC_3, 1'b0};
            8'h02, 8'h12:
                dec = '{CIT_BY_3, CIT_CYC_4, 1'b0};
            8'h22, 8'h32:
                dec = '{CIT_BY_1, CIT_CYC_5, 1'b0};
            8'h73:
                dec = '{CIT_BY_1, CIT_CYC_3, 1'b0};
            // No operation, including the spare opcode
            8'h00, 8'hA5:
                dec = '{CIT_BY_1, CIT_CYC_1, 1'b0};
            default:
                dec = '{CIT_BY_1, CIT_CYC_1, 1'b0};
        endcase
    end

    // ************************************************************
    // Instruction length
    // ************************************************************
    assign taken     = dec.cond & COND_TAKEN;
    // Taken branch costs one clock more
    assign total_raw = dec.cycles + (taken ? CIT_TAKEN_PENALTY : CIT_CYC_0);
    // Clamp to the longest instruction
    assign total     = (total_raw > CIT_CYC_MAX) ? CIT_CYC_MAX : total_raw;
    assign accept    = s_q.ready & OPC_VALID;

    // ************************************************************
    // Cycle sequencer
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (accept) begin
            // First clock of the instruction
            s_d.state  = CIT_EXEC;
            s_d.remain = total;
            s_d.num    = CIT_CYC_1;
            s_d.total  = total;
            s_d.bytes  = dec.bytes;
            s_d.taken  = taken;
            s_d.busy   = 1'b1;
            s_d.done   = (total == CIT_CYC_1);
            s_d.ready  = (total == CIT_CYC_1);
        end else begin
            unique case (s_q.state)
                CIT_IDLE: begin
                    s_d.busy  = 1'b0;
                    s_d.ready = 1'b1;
                    s_d.num   = CIT_CYC_0;
                end
                CIT_EXEC: begin
                    if (s_q.remain > CIT_CYC_1) begin
                        // One system clock per step
                        s_d.remain = s_q.remain - CIT_CYC_1;
                        s_d.num    = s_q.num + CIT_CYC_1;
                        s_d.done   = (s_q.remain == CIT_CYC_2);
                        s_d.ready  = (s_q.remain == CIT_CYC_2);
                    end else begin
                        s_d.state  = CIT_IDLE;
                        s_d.remain = CIT_CYC_0;
                        s_d.num    = CIT_CYC_0;
                        s_d.busy   = 1'b0;
                        s_d.ready  = 1'b1;
                    end
                end
                // Illegal state code: recover to idle
                default: begin
                    s_d = CIT_RESET;
                end
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= CIT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Program byte fetch, one byte per clock
    // ************************************************************
    cit_byte_seq i_cit_byte_seq (
        .clk        (REF_CLK),
        .rst_n      (RST_N),
        .load       (accept),
        .load_bytes (dec.bytes),
        .fetch      (PROG_FETCH),
        .fetch_idx  (FETCH_INDEX)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign OPC_READY    = s_q.ready;
    assign BUSY         = s_q.busy;
    assign DONE         = s_q.done;
    assign CYCLE_TOTAL  = s_q.total;
    assign CYCLE_NUM    = s_q.num;
    assign BYTE_COUNT   = s_q.bytes;
    assign BRANCH_TAKEN = s_q.taken;

endmodule

`default_nettype wire

// file: bench/cit_timing_ctrl_chk.sv
/*
 * Checker for the instruction cycle timing controller.
 * Assumes it is bound to the top module and sees its ports only.
 */
`default_nettype none

module cit_timing_ctrl_chk
    import cit_pkg::*;
(
    // Clock and reset
    input wire logic                REF_CLK,
    input wire logic                RST_N,
    // Opcode interface
    input wire logic                OPC_VALID,
    input wire logic [7:0]          OPC,
    input wire logic                COND_TAKEN,
    input wire logic                OPC_READY,
    // Status and fetch
    input wire logic                BUSY,
    input wire logic                DONE,
    input wire cit_pkg::cit_cnt_t   CYCLE_TOTAL,
    input wire cit_pkg::cit_cnt_t   CYCLE_NUM,
    input wire cit_pkg::cit_bytes_t BYTE_COUNT,
    input wire logic                BRANCH_TAKEN,
    input wire logic                PROG_FETCH,
    input wire cit_pkg::cit_bytes_t FETCH_INDEX
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    // ************************************************************
    // Sequences
    // ************************************************************
    sequence s_accept;
        OPC_VALID && OPC_READY;
    endsequence

    sequence s_start;
        BUSY && CYCLE_NUM == 4'h1;
    endsequence

    // ************************************************************
    // Properties
    // ************************************************************
    a_accept_starts: assert property (
        s_accept |=> s_start ##0 PROG_FETCH && FETCH_INDEX == 2'h1)
        else $error("accepted opcode did not start");
    a_done_at_total: assert property (
        BUSY |-> DONE == (CYCLE_NUM == CYCLE_TOTAL))
        else $error("done pulse not in last cycle");
    a_num_steps: assert property (
        BUSY && !DONE |=> BUSY && $stable(CYCLE_TOTAL)
            && CYCLE_NUM == $past(CYCLE_NUM) + 4'h1)
        else $error("cycle number did not advance");
    a_max_eight: assert property (
        s_start |-> CYCLE_TOTAL <= 4'h8 ##[0:7] DONE)
        else $error("instruction longer than eight cycles");
    a_fetch_window: assert property (
        BUSY |-> PROG_FETCH == (CYCLE_NUM <= 4'(BYTE_COUNT))
            && BYTE_COUNT != 2'h0 && 4'(BYTE_COUNT) <= CYCLE_TOTAL)
        else $error("fetch strobe outside byte window");
    a_fetch_index: assert property (
        PROG_FETCH |-> FETCH_INDEX == CYCLE_NUM[1:0])
        else $error("fetch index differs from cycle number");
    a_ready_rule: assert property (
        OPC_READY == (!BUSY || DONE))
        else $error("ready level wrong");
    a_idle_quiet: assert property (
        !BUSY |-> CYCLE_NUM == 4'h0 && !DONE && !PROG_FETCH)
        else $error("idle outputs not quiet");
    a_branch_gap: assert property (
        s_accept ##0 OPC == 8'h40 |=> BRANCH_TAKEN == $past(COND_TAKEN)
            && CYCLE_TOTAL == 4'h2 + 4'($past(COND_TAKEN)))
        else $error("carry jump length wrong");
    a_div_eight: assert property (
        s_accept ##0 OPC == 8'h84 |=> CYCLE_TOTAL == 4'h8 ##7 DONE)
        else $error("divide did not take eight cycles");
    a_one_cycle: assert property (
        s_accept ##0 OPC == 8'h28 |=> DONE && CYCLE_TOTAL == 4'h1)
        else $error("register add not one cycle");
    a_ext_move: assert property (
        s_accept ##0 OPC == 8'hE0 |=> BYTE_COUNT == 2'h1 && !DONE
            ##1 !DONE ##1 DONE)
        else $error("external move not three cycles");
endmodule

`default_nettype wire

// file: bench/cit_timing_ctrl_tb.sv
/*
 * Self-checking bench for the instruction cycle timing controller.
 * Assumes the checker file is compiled with it.
 */
`default_nettype none

module cit_timing_ctrl_tb import cit_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic             ref_clk, rst_n, opc_valid, cond_taken;
    logic [7:0]       opc;
    logic             opc_ready, busy, done, branch_taken, prog_fetch;
    cit_cnt_t         cycle_total, cycle_num;
    cit_bytes_t       byte_count, fetch_index;
    int               fails, check_count;

    localparam logic [16:0] IDLE = 17'h04000;
    // Opcode, byte count, cycle count
    localparam logic [15:0] OPS [47] = '{
        16'h2811, 16'h3811, 16'h9811,
        16'h2522, 16'h2422, 16'h3522,
        16'h3422, 16'h9522, 16'h9422,
        16'h2612, 16'h3612, 16'h9612,
        16'h5811, 16'h4811, 16'h6811,
        16'h5612, 16'h4612, 16'h6612,
        16'h5222, 16'h4222, 16'h6222,
        16'h5333, 16'h4333, 16'h6333,
        16'hE411, 16'hF411, 16'h2311, 16'h3311,
        16'h0311, 16'h1311, 16'hC411,
        16'h8822, 16'h8533,
        16'hF612, 16'h7622, 16'h9033,
        16'h9313, 16'h8313,
        16'hE213, 16'hF213, 16'hE013, 16'hF013,
        16'hC022, 16'hD022,
        16'hC811, 16'hD612,
        16'h8418};

    // ************************************************************
    // Design and clock
    // ************************************************************
    cit_timing_ctrl i_cit_timing_ctrl (
        .REF_CLK(ref_clk), .RST_N(rst_n), .OPC_VALID(opc_valid),
        .OPC(opc), .COND_TAKEN(cond_taken), .OPC_READY(opc_ready),
        .BUSY(busy), .DONE(done), .CYCLE_TOTAL(cycle_total),
        .CYCLE_NUM(cycle_num), .BYTE_COUNT(byte_count),
        .BRANCH_TAKEN(branch_taken), .PROG_FETCH(prog_fetch),
        .FETCH_INDEX(fetch_index));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [16:0] outs();
        return {busy, done, opc_ready, prog_fetch, branch_taken,
                cycle_num, cycle_total, byte_count, fetch_index};
    endfunction

    function automatic logic [16:0] exp_v(input int i, input logic tk,
                                          input cit_bytes_t eb,
                                          input cit_cnt_t ec);
        cit_bytes_t fi;
        fi = (i <= int'(eb)) ? cit_bytes_t'(i) : eb;
        return {1'b1, i == int'(ec), i == int'(ec), i <= int'(eb), tk,
                cit_cnt_t'(i), ec, eb, fi};
    endfunction

    task automatic chk(input logic [16:0] act, input logic [16:0] exp);
        check_count++;
        if (act !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, act, exp);
        end
    endtask

    task automatic end_sim();
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Offer one opcode, optionally hold a refused one while busy
    task automatic run_op(input logic [7:0] op, input logic tk,
                          input cit_bytes_t eb, input cit_cnt_t ec,
                          input logic junk);
        int n;
        n = 0;
        opc_valid  <= 1'b1;
        opc        <= op;
        cond_taken <= tk;
        do begin
            @(posedge ref_clk);
            n++;
        end while (opc_ready !== 1'b1 && n < 20);
        if (opc_ready !== 1'b1) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, opc_ready, 1'b1);
        end
        opc_valid <= junk && ec > 4'h1;
        opc       <= 8'h28;
        for (int i = 1; i <= int'(ec); i++) begin
            @(negedge ref_clk);
            chk(outs(), exp_v(i, tk, eb, ec));
            @(posedge ref_clk);
            if (i == int'(ec) - 1) opc_valid <= 1'b0;
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        chk(outs(), IDLE);
        opc_valid <= 1'b1;
        opc       <= 8'h84;
        @(posedge ref_clk);
        opc_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(outs(), exp_v(4, 1'b0, 2'h1, 4'h8));
        @(posedge ref_clk);
        rst_n <= 1'b0;
        @(negedge ref_clk);
        chk(outs(), IDLE);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) begin
            @(negedge ref_clk);
            chk(outs(), IDLE);
            @(posedge ref_clk);
        end
    endtask

    task automatic t_table();
        logic [15:0] e;
        for (int k = 0; k < 47; k++) begin
            e = OPS[k];
            run_op(e[15:8], 1'b0, e[5:4], e[3:0], k[0]);
        end
    endtask

    task automatic t_branch();
        run_op(8'h40, 1'b1, 2'h2, 4'h3, 1'b1);
        run_op(8'h40, 1'b0, 2'h2, 4'h2, 1'b0);
        run_op(8'h20, 1'b1, 2'h3, 4'h4, 1'b1);
        run_op(8'h20, 1'b0, 2'h3, 4'h3, 1'b0);
    endtask

    // Two direct adds with no idle cycle between them
    task automatic t_b2b();
        opc_valid  <= 1'b1;
        opc        <= 8'h25;
        cond_taken <= 1'b0;
        @(posedge ref_clk);
        for (int i = 1; i <= 4; i++) begin
            @(negedge ref_clk);
            chk(outs(), exp_v(2 - i % 2, 1'b0, 2'h2, 4'h2));
            @(posedge ref_clk);
            if (i == 2) opc_valid <= 1'b0;
        end
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        rst_n       = 1'b0;
        opc_valid   = 1'b0;
        opc         = 8'h00;
        cond_taken  = 1'b0;
        fails       = 0;
        check_count = 0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_table();
        t_branch();
        t_b2b();
        end_sim();
    end

    initial begin
        repeat (3000) @(posedge ref_clk);
        fails++;
        end_sim();
    end
endmodule

bind cit_timing_ctrl cit_timing_ctrl_chk i_cit_timing_ctrl_chk (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .OPC_VALID(OPC_VALID), .OPC(OPC),
    .COND_TAKEN(COND_TAKEN), .OPC_READY(OPC_READY), .BUSY(BUSY),
    .DONE(DONE), .CYCLE_TOTAL(CYCLE_TOTAL), .CYCLE_NUM(CYCLE_NUM),
    .BYTE_COUNT(BYTE_COUNT), .BRANCH_TAKEN(BRANCH_TAKEN),
    .PROG_FETCH(PROG_FETCH), .FETCH_INDEX(FETCH_INDEX));

`default_nettype wire
